// file: rtl/mcdf_pkg.sv
// Purpose: shared constants and types of the command datagram framer
// Assumes: one clock, bytes move as 8-bit words
// Notes:   status codes are used by rtl and bench alike; field positions by rtl only
package mcdf_pkg;

  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned VALUE_W    = 32;
  localparam int unsigned FRAME_LEN  = 9;   // address, seven body bytes, checksum
  localparam int unsigned LINE_LEN   = 18;  // two line bytes per datagram byte
  localparam int unsigned ENC_W      = 16;  // one datagram byte on the line

  // byte positions inside a request and inside a reply
  localparam logic [3:0] IDX_ADDR    = 4'h0;
  localparam logic [3:0] IDX_INSTR   = 4'h1;
  localparam logic [3:0] IDX_TYPE    = 4'h2;
  localparam logic [3:0] IDX_BANK    = 4'h3;
  localparam logic [3:0] IDX_VAL_MSB = 4'h4;
  localparam logic [3:0] IDX_VAL_LSB = 4'h7;
  localparam logic [3:0] IDX_CSUM    = 4'h8;
  localparam logic [3:0] IDX_R_MOD   = 4'h1;
  localparam logic [3:0] IDX_R_STAT  = 4'h2;
  localparam logic [3:0] IDX_R_INSTR = 4'h3;

  // reply status codes
  localparam logic [7:0] ST_OK       = 8'h64;  // 100
  localparam logic [7:0] ST_BAD_CSUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD  = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VAL  = 8'h04;
  localparam logic [7:0] ST_LOCKED   = 8'h05;
  localparam logic [7:0] ST_NO_CMD   = 8'h06;

  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  typedef struct packed {
    logic [7:0]  instr;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] value;
  } mcdf_cmd_t;

  typedef struct packed {
    logic [7:0]  status;
    logic [31:0] value;
  } mcdf_rsp_t;

  typedef enum logic [1:0] {
    MCDF_RX,
    MCDF_EXEC,
    MCDF_TX
  } mcdf_state_t;

endpackage : mcdf_pkg

// file: rtl/mcdf_fifo.sv
// Purpose: valid/ready fifo that holds encoded reply bytes for the line
// Assumes: single clock, DEPTH a power of two
// Notes:   out side may stall; in_ready drops honestly when full
`timescale 1ns/1ps
`default_nettype none
module mcdf_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  logic [AW:0]      nxt_wr;
  logic [AW:0]      nxt_rd;
  logic             push;
  logic             pop;

  // extra pointer bit tells full from empty
  assign in_ready  = !((wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]));
  assign out_valid = (wr_ff != rd_ff);
  assign out_data  = mem_ff[rd_ff[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer next values
  always_comb begin
    nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end

  // storage needs no reset; empty flag hides stale words
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data;
    end
  end

endmodule : mcdf_fifo
`default_nettype wire

// file: rtl/mcdf_codec.sv
// Purpose: dc-balanced byte to two-byte mapping and its inverse
// Assumes: each nibble maps to one line byte through NIB_TABLE
// Notes:   table is a parameter so encoder and decoder always share it
`timescale 1ns/1ps
`default_nettype none
module mcdf_codec #(
  // sixteen line codes of four ones each, entry n at bits [8n+7:8n]
  parameter logic [127:0] NIB_TABLE = 128'h473c_3a39_3635_332e_2d2b_271e_1d1b_170f
) (
  input  wire logic [7:0]  enc_byte,
  output logic      [15:0] enc_line,
  input  wire logic [15:0] dec_line,
  output logic      [7:0]  dec_byte,
  output logic             dec_err
);
  logic [15:0] hit_hi;
  logic [15:0] hit_lo;
  logic [3:0]  nib_hi;
  logic [3:0]  nib_lo;

  // encoder: high nibble goes on the line first
  assign enc_line = {NIB_TABLE[enc_byte[7:4]*8 +: 8], NIB_TABLE[enc_byte[3:0]*8 +: 8]};

  // decoder: compare against every table entry
  for (genvar g = 0; g < 16; g++) begin : g_match
    assign hit_hi[g] = (dec_line[15:8] == NIB_TABLE[g*8 +: 8]);
    assign hit_lo[g] = (dec_line[7:0] == NIB_TABLE[g*8 +: 8]);
  end

  // one-hot to index; no hit means a corrupted line byte
  always_comb begin
    nib_hi = 4'h0;
    nib_lo = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (hit_hi[i]) nib_hi = 4'(i);
      if (hit_lo[i]) nib_lo = 4'(i);
    end
  end

  assign dec_byte = {nib_hi, nib_lo};
  assign dec_err  = !(|hit_hi) || !(|hit_lo);

endmodule : mcdf_codec
`default_nettype wire

// file: rtl/mcdf_framer.sv
// Purpose: checks incoming request datagrams and frames the status replies
// Assumes: line bytes come from the transceiver logic on core_clk
// Notes:   one request at a time; foreign-address frames are dropped silently
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - reply sent only for a received request, after its execution finished or at once when it is refused
// - body is instruction, type, motor or bank, four-byte value
// - address byte leads, checksum byte trails, nine bytes per request
// - four-byte value travels most significant byte first
// - checksum is 8-bit sum of the first eight bytes, checked on receive
// - reply is host address, module address, status, instruction, value, checksum
// - status codes 100 ok, 1 to 6 for the listed errors
// - every datagram byte becomes two line bytes, eighteen per datagram
// - direct mode only; unsupported instructions answered with error status
module mcdf_framer #(
  parameter logic [7:0]  MOD_ADDR   = 8'h01,
  parameter logic [7:0]  REPLY_ADDR = 8'h02,
  parameter logic [31:0] CMD_MASK   = 32'h0000_00fe,  // instructions 1..7 accepted
  parameter int unsigned FIFO_DEPTH = 16
) (
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire logic                line_rx_valid,
  output logic                     line_rx_ready,
  input  wire logic [7:0]          line_rx_data,
  output logic                     line_tx_valid,
  input  wire logic                line_tx_ready,
  output logic      [7:0]          line_tx_data,
  output logic                     cmd_valid,
  output mcdf_pkg::mcdf_cmd_t      cmd_data,
  input  wire logic                exec_done,
  input  wire mcdf_pkg::mcdf_rsp_t exec_rsp
);

  mcdf_pkg::mcdf_state_t st_ff;
  mcdf_pkg::mcdf_state_t nxt_st;
  logic [3:0]          idx_ff;
  logic [3:0]          nxt_idx;
  logic                half_ff;
  logic                nxt_half;
  logic [7:0]          hi_ff;
  logic [7:0]          nxt_hi;
  logic [7:0]          sum_ff;
  logic [7:0]          nxt_sum;
  logic [7:0]          addr_ff;
  logic [7:0]          nxt_addr;
  logic                bad_ff;
  logic                nxt_bad;
  mcdf_pkg::mcdf_cmd_t cmd_ff;
  mcdf_pkg::mcdf_cmd_t nxt_cmd;
  mcdf_pkg::mcdf_rsp_t rsp_ff;
  mcdf_pkg::mcdf_rsp_t nxt_rsp;

  logic        rx_take;
  logic [7:0]  rx_byte;
  logic        rx_err;
  logic        rx_done;
  logic        csum_ok;
  logic [7:0]  tx_byte;
  logic [15:0] tx_line;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic [7:0]  fifo_in_data;
  logic        push;

  // shared lookup keeps both directions on one table
  mcdf_codec u_codec (
    .enc_byte (tx_byte),
    .enc_line (tx_line),
    .dec_line ({hi_ff, line_rx_data}),
    .dec_byte (rx_byte),
    .dec_err  (rx_err)
  );

  // reply bytes wait here so a slow line stalls the framer, not the executor
  mcdf_fifo #(
    .WIDTH (mcdf_pkg::BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (line_tx_valid),
    .out_ready (line_tx_ready),
    .out_data  (line_tx_data)
  );

  // receive only while idle; the host waits for the reply anyway
  assign line_rx_ready = (st_ff == mcdf_pkg::MCDF_RX);
  assign rx_take       = line_rx_valid && line_rx_ready;
  assign rx_done       = rx_take && half_ff && (idx_ff == mcdf_pkg::IDX_CSUM);
  assign csum_ok       = !bad_ff && !rx_err && (sum_ff == rx_byte);

  assign cmd_valid = (st_ff == mcdf_pkg::MCDF_EXEC);
  assign cmd_data  = cmd_ff;

  // reply byte for the current position
  always_comb begin
    case (idx_ff)
      mcdf_pkg::IDX_ADDR:    tx_byte = REPLY_ADDR;
      mcdf_pkg::IDX_R_MOD:   tx_byte = MOD_ADDR;
      mcdf_pkg::IDX_R_STAT:  tx_byte = rsp_ff.status;
      mcdf_pkg::IDX_R_INSTR: tx_byte = cmd_ff.instr;
      4'h4:                  tx_byte = rsp_ff.value[31:24];
      4'h5:                  tx_byte = rsp_ff.value[23:16];
      4'h6:                  tx_byte = rsp_ff.value[15:8];
      4'h7:                  tx_byte = rsp_ff.value[7:0];
      mcdf_pkg::IDX_CSUM:    tx_byte = sum_ff;
      default:               tx_byte = mcdf_pkg::BYTE_ZERO;
    endcase
  end

  assign fifo_in_valid = (st_ff == mcdf_pkg::MCDF_TX);
  assign fifo_in_data  = half_ff ? tx_line[7:0] : tx_line[15:8];
  assign push          = fifo_in_valid && fifo_in_ready;

  // next state of the whole datagram engine
  always_comb begin
    nxt_st   = st_ff;
    nxt_idx  = idx_ff;
    nxt_half = half_ff;
    nxt_hi   = hi_ff;
    nxt_sum  = sum_ff;
    nxt_addr = addr_ff;
    nxt_bad  = bad_ff;
    nxt_cmd  = cmd_ff;
    nxt_rsp  = rsp_ff;
    case (st_ff)
      mcdf_pkg::MCDF_RX: begin
        if (rx_take && !half_ff) begin
          nxt_hi   = line_rx_data;
          nxt_half = 1'b1;
        end else if (rx_take) begin
          nxt_half = 1'b0;
          nxt_bad  = bad_ff || rx_err;
          nxt_idx  = idx_ff + 4'h1;
          nxt_sum  = sum_ff + rx_byte;
          case (idx_ff)
            mcdf_pkg::IDX_ADDR:  nxt_addr = rx_byte;
            mcdf_pkg::IDX_INSTR: nxt_cmd.instr = rx_byte;
            mcdf_pkg::IDX_TYPE:  nxt_cmd.typ = rx_byte;
            mcdf_pkg::IDX_BANK:  nxt_cmd.bank = rx_byte;
            default: begin
              if (idx_ff <= mcdf_pkg::IDX_VAL_LSB) begin
                nxt_cmd.value = {cmd_ff.value[23:0], rx_byte};
              end
            end
          endcase
          if (rx_done) begin
            nxt_idx = mcdf_pkg::IDX_ADDR;
            nxt_sum = mcdf_pkg::BYTE_ZERO;
            nxt_bad = 1'b0;
            if (addr_ff != MOD_ADDR) begin
              nxt_st = mcdf_pkg::MCDF_RX; // not ours: no reply at all
            end else if (!csum_ok) begin
              nxt_rsp = '{status: mcdf_pkg::ST_BAD_CSUM, value: '0};
              nxt_st  = mcdf_pkg::MCDF_TX;
            end else if (cmd_ff.instr >= 8'd32 || !CMD_MASK[cmd_ff.instr[4:0]]) begin
              nxt_rsp = '{status: mcdf_pkg::ST_BAD_CMD, value: '0};
              nxt_st  = mcdf_pkg::MCDF_TX;
            end else begin
              nxt_st = mcdf_pkg::MCDF_EXEC;
            end
          end
        end
      end
      mcdf_pkg::MCDF_EXEC: begin
        if (exec_done) begin
          nxt_rsp = exec_rsp;
          nxt_st  = mcdf_pkg::MCDF_TX;
        end
      end
      mcdf_pkg::MCDF_TX: begin
        if (push && !half_ff) begin
          nxt_half = 1'b1;
        end else if (push) begin
          nxt_half = 1'b0;
          nxt_sum  = sum_ff + tx_byte;
          nxt_idx  = idx_ff + 4'h1;
          if (idx_ff == mcdf_pkg::IDX_CSUM) begin
            nxt_idx = mcdf_pkg::IDX_ADDR;
            nxt_sum = mcdf_pkg::BYTE_ZERO;
            nxt_st  = mcdf_pkg::MCDF_RX;
          end
        end
      end
      default: nxt_st = mcdf_pkg::MCDF_RX;
    endcase
  end

  // register stage only
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_ff   <= mcdf_pkg::MCDF_RX;
      idx_ff  <= mcdf_pkg::IDX_ADDR;
      half_ff <= 1'b0;
      hi_ff   <= mcdf_pkg::BYTE_ZERO;
      sum_ff  <= mcdf_pkg::BYTE_ZERO;
      addr_ff <= mcdf_pkg::BYTE_ZERO;
      bad_ff  <= 1'b0;
      cmd_ff  <= '0;
      rsp_ff  <= '0;
    end else begin
      st_ff   <= nxt_st;
      idx_ff  <= nxt_idx;
      half_ff <= nxt_half;
      hi_ff   <= nxt_hi;
      sum_ff  <= nxt_sum;
      addr_ff <= nxt_addr;
      bad_ff  <= nxt_bad;
      cmd_ff  <= nxt_cmd;
      rsp_ff  <= nxt_rsp;
    end
  end

  // helper: line bytes pushed during one reply, datagram bytes in one request
  logic [4:0] push_cnt_ff;
  logic [3:0] rx_cnt_ff;
  always_ff @(posedge core_clk) begin
    if (!nrst || st_ff != mcdf_pkg::MCDF_TX) begin
      push_cnt_ff <= '0;
    end else if (push) begin
      push_cnt_ff <= push_cnt_ff + 5'd1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!nrst || rx_done) begin
      rx_cnt_ff <= '0;
    end else if (rx_take && half_ff) begin
      rx_cnt_ff <= rx_cnt_ff + 4'd1;
    end
  end

  property p_push_only_tx;
    @(posedge core_clk) disable iff (!nrst)
    // a reply may only open right after a refused request or a finished execution
    $rose(fifo_in_valid) |-> $past(rx_done) || ($past(cmd_valid) && $past(exec_done));
  endproperty
  a_push_only_tx: assert property (p_push_only_tx) else $error("reply started without a request");

  property p_exec_hold;
    @(posedge core_clk) disable iff (!nrst)
    cmd_valid && !exec_done |=> cmd_valid && $stable(cmd_data);
  endproperty
  a_exec_hold: assert property (p_exec_hold) else $error("command dropped early");

  property p_done_to_tx;
    @(posedge core_clk) disable iff (!nrst)
    cmd_valid && exec_done |=> (st_ff == mcdf_pkg::MCDF_TX) && (rsp_ff == $past(exec_rsp));
  endproperty
  a_done_to_tx: assert property (p_done_to_tx) else $error("reply not started");

  property p_rx_blocked;
    @(posedge core_clk) disable iff (!nrst)
    rx_done && (addr_ff == MOD_ADDR) |=> !line_rx_ready && (st_ff != mcdf_pkg::MCDF_RX);
  endproperty
  a_rx_blocked: assert property (p_rx_blocked) else $error("rx open while busy");

  property p_first_byte;
    @(posedge core_clk) disable iff (!nrst)
    $rose(fifo_in_valid) |-> (idx_ff == mcdf_pkg::IDX_ADDR) && !half_ff && (tx_byte == REPLY_ADDR);
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("reply does not open with address");

  property p_csum_bad;
    @(posedge core_clk) disable iff (!nrst)
    rx_done && (addr_ff == MOD_ADDR) && !csum_ok
      |=> (st_ff == mcdf_pkg::MCDF_TX) && (rsp_ff.status == mcdf_pkg::ST_BAD_CSUM);
  endproperty
  a_csum_bad: assert property (p_csum_bad) else $error("bad checksum not reported");

  property p_value_order;
    @(posedge core_clk) disable iff (!nrst)
    rx_take && half_ff && (idx_ff == mcdf_pkg::IDX_VAL_LSB)
      |=> cmd_ff.value[31:8] == $past(cmd_ff.value[23:0]);
  endproperty
  a_value_order: assert property (p_value_order) else $error("value byte order");

  property p_line_len;
    @(posedge core_clk) disable iff (!nrst)
    (st_ff == mcdf_pkg::MCDF_TX) ##1 (st_ff == mcdf_pkg::MCDF_RX) |-> $past(push_cnt_ff) == 5'd17;
  endproperty
  a_line_len: assert property (p_line_len) else $error("reply not eighteen line bytes");

  property p_nine_bytes;
    @(posedge core_clk) disable iff (!nrst)
    rx_done |-> rx_cnt_ff == 4'd8;
  endproperty
  a_nine_bytes: assert property (p_nine_bytes) else $error("request length wrong");

  property p_unsupported;
    @(posedge core_clk) disable iff (!nrst)
    rx_done && (addr_ff == MOD_ADDR) && csum_ok && (cmd_ff.instr >= 8'd32)
      |=> (rsp_ff.status == mcdf_pkg::ST_BAD_CMD) && !cmd_valid;
  endproperty
  a_unsupported: assert property (p_unsupported) else $error("unsupported command executed");

endmodule : mcdf_framer
`default_nettype wire

// file: verification/mcdf_host_model.sv
// Purpose: host side of the line, sends encoded requests and decodes replies
// Assumes: same clock as the framer, one request in flight at a time
// Notes:   idle line data shows the inverse of the last byte so stale values never match
`timescale 1ns/1ps
`default_nettype none
module mcdf_host_model (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         req_go,
  input  wire logic [71:0]  req_frame,
  input  wire logic         stall,
  output logic              line_rx_valid,
  input  wire logic         line_rx_ready,
  output logic      [7:0]   line_rx_data,
  input  wire logic         line_tx_valid,
  output logic              line_tx_ready,
  input  wire logic [7:0]   line_tx_data,
  output logic              busy,
  output logic              rsp_done,
  output logic      [71:0]  rsp_frame
);
  // line code of each nibble, the table the framer is built with
  localparam logic [7:0] TBL [16] = '{8'h0f, 8'h17, 8'h1b, 8'h1d, 8'h1e, 8'h27, 8'h2b, 8'h2d,
                                      8'h2e, 8'h33, 8'h35, 8'h36, 8'h39, 8'h3a, 8'h3c, 8'h47};
  logic [143:0] tx_sh_ff;
  logic [4:0]   tx_cnt_ff;
  logic [7:0]   last_ff;
  logic [143:0] rx_sh_ff;
  logic [4:0]   rx_cnt_ff;

  // each datagram byte goes out as two line bytes, high nibble code first
  function automatic logic [143:0] lenc(input logic [71:0] f);
    for (int i = 0; i < 18; i++) begin
      lenc[8*i +: 8] = TBL[f[4*i +: 4]];
    end
  endfunction : lenc

  // an unknown code decodes to x so that any compare against it fails
  function automatic logic [71:0] ldec(input logic [143:0] l);
    for (int i = 0; i < 18; i++) begin
      ldec[4*i +: 4] = 4'bxxxx;
      for (int j = 0; j < 16; j++) begin
        if (TBL[j] === l[8*i +: 8]) ldec[4*i +: 4] = j[3:0];
      end
    end
  endfunction : ldec

  // outputs come from flops or straight from the stall input, so they settle right after the edge
  assign line_rx_valid = (tx_cnt_ff != 5'h0);
  assign line_rx_data  = line_rx_valid ? tx_sh_ff[143:136] : ~last_ff;
  assign line_tx_ready = ~stall;
  assign busy          = line_rx_valid;

  // sender holds byte and valid until the framer takes it
  always_ff @(posedge core_clk) begin
    rsp_done <= 1'b0;
    if (!nrst) begin
      tx_cnt_ff <= 5'h0;
      rx_cnt_ff <= 5'h0;
      last_ff   <= 8'h00;
    end else begin
      if (req_go && !busy) begin
        tx_sh_ff  <= lenc(req_frame);
        tx_cnt_ff <= 5'd18;
      end else if (line_rx_valid && line_rx_ready) begin
        tx_sh_ff  <= tx_sh_ff << 8;
        last_ff   <= tx_sh_ff[143:136];
        tx_cnt_ff <= tx_cnt_ff - 5'h1;
      end
      if (line_tx_valid && line_tx_ready) begin
        rx_sh_ff  <= {rx_sh_ff[135:0], line_tx_data};
        rx_cnt_ff <= (rx_cnt_ff == 5'd17) ? 5'h0 : rx_cnt_ff + 5'h1;
        if (rx_cnt_ff == 5'd17) begin
          rsp_done  <= 1'b1;
          rsp_frame <= ldec({rx_sh_ff[135:0], line_tx_data});
        end
      end
    end
  end
endmodule : mcdf_host_model
`default_nettype wire

// file: verification/mcdf_framer_tb.sv
// Purpose: self-checking bench of the datagram framer against the host model
// Assumes: bench plays the executor; addresses differ from the defaults
// Notes:   expected replies are built here from the field order and the sum
`timescale 1ns/1ps
`default_nettype none
module mcdf_framer_tb;
  localparam logic [7:0] MOD = 8'h05;
  localparam logic [7:0] RPL = 8'h0a;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic exec_done = 1'b0;
  mcdf_pkg::mcdf_rsp_t exec_rsp = '0;
  logic req_go = 1'b0;
  logic [71:0] req_frame = '0;
  logic stall = 1'b0;
  logic line_rx_valid, line_rx_ready, line_tx_valid, line_tx_ready, cmd_valid, busy, rsp_done;
  logic [7:0] line_rx_data, line_tx_data;
  logic [71:0] rsp_frame, got;
  mcdf_pkg::mcdf_cmd_t cmd_data;
  int errors = 0;
  int n_tests = 0;
  int n_cmd;

  always #5 core_clk = ~core_clk;

  mcdf_framer #(.MOD_ADDR(MOD), .REPLY_ADDR(RPL)) u_dut (.core_clk(core_clk), .nrst(nrst),
    .line_rx_valid(line_rx_valid), .line_rx_ready(line_rx_ready), .line_rx_data(line_rx_data),
    .line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready), .line_tx_data(line_tx_data),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data), .exec_done(exec_done), .exec_rsp(exec_rsp));
  mcdf_host_model u_host (.core_clk(core_clk), .nrst(nrst), .req_go(req_go),
    .req_frame(req_frame), .stall(stall), .line_rx_valid(line_rx_valid),
    .line_rx_ready(line_rx_ready), .line_rx_data(line_rx_data), .line_tx_valid(line_tx_valid),
    .line_tx_ready(line_tx_ready), .line_tx_data(line_tx_data), .busy(busy),
    .rsp_done(rsp_done), .rsp_frame(rsp_frame));

  task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] seen);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // the trailing byte is the 8-bit sum of the eight before it
  function automatic logic [71:0] seal(input logic [63:0] b);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) s = s + b[8*i +: 8];
    return {b, s};
  endfunction : seal

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // the next request waits only until the host has finished sending the last request on the line
  task automatic send(input logic [71:0] f);
    while (busy !== 1'b0) @(posedge core_clk);
    @(posedge core_clk);
    req_go    <= 1'b1;
    req_frame <= f;
    @(posedge core_clk);
    req_go <= 1'b0;
  endtask : send

  // waits a bounded time for a reply, counting cycles with a command offered
  task automatic wait_rsp(output logic [71:0] r);
    r     = 'x;
    n_cmd = 0;
    for (int i = 0; i < 300; i++) begin
      @(posedge core_clk);
      #1;
      if (cmd_valid !== 1'b0) n_cmd++;
      if (rsp_done === 1'b1) begin
        r = rsp_frame;
        break;
      end
    end
  endtask : wait_rsp

  // full command round trip, optionally with the host stalling the reply
  task automatic t_cmd(input logic [7:0] ins, input logic [7:0] st, input logic [31:0] v,
                       input bit stl);
    logic [7:0] d0;
    send(seal({MOD, ins, 8'h03, 8'h01, v}));
    for (int i = 0; i < 40 && cmd_valid !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk("cmd_data", {16'h0, ins, 8'h03, 8'h01, v}, 72'(cmd_data));
    repeat (5) @(posedge core_clk);
    #1;
    chk("tx before exec", 72'h0, 72'(line_tx_valid));
    @(posedge core_clk);
    stall <= stl;
    exec_done <= 1'b1;
    exec_rsp  <= {st, ~v};
    @(posedge core_clk);
    exec_done <= 1'b0;
    if (stl) begin
      repeat (30) @(posedge core_clk);
      #1;
      d0 = line_tx_data;
      chk("tx stalled valid", 72'h1, 72'(line_tx_valid));
      repeat (10) @(posedge core_clk);
      #1;
      chk("tx stalled data", 72'(d0), 72'(line_tx_data));
      // reply address 0a opens with the line code of nibble 0
      chk("tx first code", 72'h0f, 72'(d0));
      @(posedge core_clk);
      stall <= 1'b0;
    end
    wait_rsp(got);
    chk("reply", seal({RPL, MOD, st, ins, ~v}), got);
  endtask : t_cmd

  // refused request: no command offered, error status with value zero
  task automatic t_refuse(input logic [71:0] f, input logic [7:0] st);
    send(f);
    wait_rsp(got);
    chk("refused cmd", 72'h0, 72'(n_cmd));
    chk("refused reply", seal({RPL, MOD, st, f[63:56], 32'h0}), got);
  endtask : t_refuse

  task automatic t_foreign;
    send(seal({MOD + 8'h01, 8'h01, 8'h00, 8'h00, 32'h0000_01f4}));
    wait_rsp(got);
    chk("foreign reply", 72'h0, 72'(rsp_done));
    chk("foreign cmd", 72'h0, 72'(n_cmd));
    t_cmd(8'h01, mcdf_pkg::ST_OK, 32'h0000_01f4, 1'b0);
  endtask : t_foreign

  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("reset", 72'h4, {69'h0, line_rx_ready, line_tx_valid, cmd_valid});
    t_cmd(8'h01, mcdf_pkg::ST_OK, 32'h1234_5678, 1'b0);
    t_cmd(8'h02, mcdf_pkg::ST_BAD_TYPE, 32'h8000_0001, 1'b0);
    t_cmd(8'h03, mcdf_pkg::ST_BAD_VAL, 32'hff00_ff00, 1'b0);
    t_cmd(8'h04, mcdf_pkg::ST_LOCKED, 32'h0000_0000, 1'b0);
    t_cmd(8'h05, mcdf_pkg::ST_NO_CMD, 32'hffff_ffff, 1'b0);
    t_cmd(8'h07, mcdf_pkg::ST_OK, 32'hdead_beef, 1'b1);
    t_refuse(seal({MOD, 8'h01, 8'h00, 8'h00, 32'h0000_01f4}) ^ 72'h1, mcdf_pkg::ST_BAD_CSUM);
    t_refuse(seal({MOD, 8'h00, 8'h00, 8'h00, 32'h0000_0000}), mcdf_pkg::ST_BAD_CMD);
    t_refuse(seal({MOD, 8'h08, 8'h00, 8'h00, 32'h0000_0000}), mcdf_pkg::ST_BAD_CMD);
    t_refuse(seal({MOD, 8'h28, 8'h00, 8'h00, 32'h0000_0000}), mcdf_pkg::ST_BAD_CMD);
    t_foreign();
    end_sim();
  end

  // cut a hang short well beyond the expected run length
  initial begin
    #200000;
    errors++;
    end_sim();
  end
endmodule : mcdf_framer_tb
`default_nettype wire
